//--- hdl/wwdt_defs.svh
`ifndef WWDT_DEFS_SVH
`define WWDT_DEFS_SVH

// Register byte offsets
`define WWDT_ADR_CTRL 4'h0
`define WWDT_ADR_CFG 4'h4
`define WWDT_ADR_STAT 4'h8
`define WWDT_ADR_CNT 4'hC

// Control register fields
`define WWDT_CTRL_SWEN 0
`define WWDT_CTRL_SLEEPF 1
`define WWDT_CTRL_IDLEF 2

// Configuration register fields
`define WWDT_CFG_PS_LO 0
`define WWDT_CFG_PS_HI 3
`define WWDT_CFG_PSA 4
`define WWDT_CFG_WINDOW_DISABLE_CFG 7
`define WWDT_CFG_EN_LO 8
`define WWDT_CFG_EN_HI 9
`define WWDT_CFG_RST 32'h0000_0300

// Status register fields
`define WWDT_STAT_TO 0
`define WWDT_STAT_EARLY 1
`define WWDT_STAT_RUN 2

// Enable modes
`define WWDT_EN_ON 2'h3
`define WWDT_EN_SW 2'h2

// Prescaler terminal counts
`define WWDT_PRE_DIV5 7'h1F
`define WWDT_PRE_DIV7 7'h7F

// Timing figures
`define WWDT_LOW_POWER_RC_OSC_HZ 31000
`define WWDT_CLK_HZ 10000000

`endif

//--- hdl/wwdt_pkg.sv
package wwdt_pkg;
    typedef enum logic [1:0] {
        RUN_ST,
        SLEEP_ST,
        IDLE_ST
    } wwdt_pwr_e;
    typedef logic [14:0] wwdt_post_t;
endpackage : wwdt_pkg

//--- hdl/wwdt_low_power_rc_osc.sv
`timescale 1ns/1ps
`include "wwdt_defs.svh"

// Low-power RC model: a tick every CLK_HZ/LOW_POWER_RC_OSC_HZ core cycles while on.
module wwdt_low_power_rc_osc #(
    parameter int CLK_HZ = `WWDT_CLK_HZ,
    parameter int LOW_POWER_RC_OSC_HZ = `WWDT_LOW_POWER_RC_OSC_HZ
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic osc_on,
    output logic tick
);
    localparam int DIV = (CLK_HZ / LOW_POWER_RC_OSC_HZ) < 1 ? 1 : CLK_HZ / LOW_POWER_RC_OSC_HZ;
    localparam logic [15:0] LAST = 16'(DIV - 1);
    logic [15:0] cnt_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 16'h0000;
            tick <= 1'b0;
        end else if (ce) begin
            tick <= 1'b0;
            if (!osc_on) begin
                cnt_q <= 16'h0000;
            end else if (cnt_q == LAST) begin
                cnt_q <= 16'h0000;
                tick <= 1'b1;
            end else begin
                cnt_q <= cnt_q + 16'h0001;
            end
        end
    end
endmodule : wwdt_low_power_rc_osc

//--- hdl/wwdt_div.sv
`timescale 1ns/1ps
`include "wwdt_defs.svh"

// Prescaler: 5-bit or 7-bit divide of the oscillator tick.
module wwdt_div (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic clr,
    input wire logic tick,
    input wire logic div7,
    output logic pre_tick
);
    logic [6:0] cnt_q;
    logic [6:0] last;

    assign last = div7 ? `WWDT_PRE_DIV7 : `WWDT_PRE_DIV5;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 7'h00;
            pre_tick <= 1'b0;
        end else if (ce) begin
            pre_tick <= 1'b0;
            if (clr) begin
                cnt_q <= 7'h00;
            end else if (tick) begin
                if (cnt_q >= last) begin
                    cnt_q <= 7'h00;
                    pre_tick <= 1'b1;
                end else begin
                    cnt_q <= cnt_q + 7'h01;
                end
            end
        end
    end
endmodule : wwdt_div

//--- hdl/wwdt_top.sv
// Notes on behaviour
// - Counts on the low-power RC tick; enabling turns that oscillator on.
// - Prescaler divides by 32 or by 128 per select bit.
// - Nominal 31 kHz input gives about 1 ms or 4 ms base period.
// - Postscaler ratio 1:1 to 1:32768 chosen by four-bit field.
// - All counts clear on reset, clock switch, sleep entry/exit, clear.
// - Counting continues during sleep or idle when enabled.
// - Time-out in sleep or idle wakes the core instead of resetting.
// - Time-out flag is sticky until software clears it.
// - Windowed: clear works only in last quarter; earlier clear resets. The code opens the window fully for ratios 1:1 and 1:2.
// - Windowed mode active when window-disable bit is zero.
// - Enable field: 11 always on, 10 software, 00 always off.
// - In software mode the software-enable bit starts and stops it.
// - Software-enable bit is zero after any device reset.
//
// Added by the designer: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "wwdt_defs.svh"

module wwdt_top #(
    parameter int CLK_HZ = `WWDT_CLK_HZ,
    parameter int LOW_POWER_RC_OSC_HZ = `WWDT_LOW_POWER_RC_OSC_HZ
) (
    input wire logic CORE_CLK,
    input wire logic SYS_RST,
    input wire logic CLK_EN,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [3:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    input wire logic WATCHDOG_CLEAR_INSTR,
    input wire logic POWER_SAVE_INSTR,
    input wire logic POWER_SAVE_IDLE,
    input wire logic WAKE_OTHER,
    input wire logic CLK_SWITCH_DONE,
    output logic WAKE_REQ,
    output logic WDT_RESET_REQ,
    output logic LOW_POWER_RC_OSC_EN
);
    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    logic sw_en_q;
    logic sleep_flag_q;
    logic idle_flag_q;
    logic [31:0] cfg_q;
    logic timeout_flag_q;
    logic early_flag_q;
    logic wb_req;
    logic wr_ctrl;
    logic wr_cfg;
    logic wr_stat;
    logic [3:0] ps_cfg;
    logic [1:0] en_cfg;
    logic enabled;
    logic window_on;
    logic timeout_ev;
    logic early_ev;
    logic clr_ok;
    logic wake_ev;
    logic enter_ev;
    logic cnt_clr;
    logic tick;
    logic pre_tick;
    wwdt_pkg::wwdt_pwr_e pwr_q;
    wwdt_pkg::wwdt_post_t post_q;
    wwdt_pkg::wwdt_post_t post_last;

    function automatic logic wr_bit(input logic [31:0] d,
                                    input logic [3:0] sel,
                                    input int idx,
                                    input logic cur);
        wr_bit = sel[idx / 8] ? d[idx] : cur;
    endfunction : wr_bit

    assign wb_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    assign wr_ctrl = wb_req && WB_WE_I && WB_ADR_I == `WWDT_ADR_CTRL;
    assign wr_cfg = wb_req && WB_WE_I && WB_ADR_I == `WWDT_ADR_CFG;
    assign wr_stat = wb_req && WB_WE_I && WB_ADR_I == `WWDT_ADR_STAT;

    always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= 32'h0000_0000;
        end else if (CLK_EN) begin
            WB_ACK_O <= wb_req;
            WB_DAT_O <= 32'h0000_0000;
            if (wb_req && !WB_WE_I) begin
                unique case (WB_ADR_I)
                    `WWDT_ADR_CTRL: WB_DAT_O <= {29'h0, idle_flag_q,
                                                 sleep_flag_q, sw_en_q};
                    `WWDT_ADR_CFG: WB_DAT_O <= cfg_q;
                    `WWDT_ADR_STAT: WB_DAT_O <= {29'h0, enabled,
                                                 early_flag_q,
                                                 timeout_flag_q};
                    `WWDT_ADR_CNT: WB_DAT_O <= {17'h0, post_q};
                    default: WB_DAT_O <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Software enable cleared only by reset or a software write
    always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            sw_en_q <= 1'b0;
        end else if (CLK_EN && wr_ctrl) begin
            sw_en_q <= wr_bit(WB_DAT_I, WB_SEL_I, `WWDT_CTRL_SWEN, sw_en_q);
        end
    end

    // Power-save flags: hardware sets on entry, only reset or software clears
    always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            sleep_flag_q <= 1'b0;
            idle_flag_q <= 1'b0;
        end else if (CLK_EN) begin
            if (wr_ctrl) begin
                sleep_flag_q <= wr_bit(WB_DAT_I, WB_SEL_I,
                                       `WWDT_CTRL_SLEEPF, sleep_flag_q);
                idle_flag_q <= wr_bit(WB_DAT_I, WB_SEL_I,
                                      `WWDT_CTRL_IDLEF, idle_flag_q);
            end
            if (enter_ev && !POWER_SAVE_IDLE) begin
                sleep_flag_q <= 1'b1;
            end
            if (enter_ev && POWER_SAVE_IDLE) begin
                idle_flag_q <= 1'b1;
            end
        end
    end

    // Configuration word is writable so a bench can pick modes
    always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            cfg_q <= `WWDT_CFG_RST;
        end else if (CLK_EN && wr_cfg) begin
            for (int b = 0; b < 4; b++) begin
                if (WB_SEL_I[b]) begin
                    cfg_q[b*8 +: 8] <= WB_DAT_I[b*8 +: 8];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------------
    assign ps_cfg = cfg_q[`WWDT_CFG_PS_HI:`WWDT_CFG_PS_LO];
    assign en_cfg = cfg_q[`WWDT_CFG_EN_HI:`WWDT_CFG_EN_LO];
    assign enabled = en_cfg == `WWDT_EN_ON ||
                     (en_cfg == `WWDT_EN_SW && sw_en_q);
    assign window_on = !cfg_q[`WWDT_CFG_WINDOW_DISABLE_CFG];

    // ------------------------------------------------------------------
    // Power state tracking
    // ------------------------------------------------------------------
    assign enter_ev = POWER_SAVE_INSTR && pwr_q == wwdt_pkg::RUN_ST;
    assign wake_ev = pwr_q != wwdt_pkg::RUN_ST &&
                     (WAKE_OTHER || (timeout_ev && enabled));

    always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            pwr_q <= wwdt_pkg::RUN_ST;
        end else if (CLK_EN) begin
            unique case (pwr_q)
                wwdt_pkg::RUN_ST: begin
                    if (POWER_SAVE_INSTR) begin
                        pwr_q <= POWER_SAVE_IDLE ? wwdt_pkg::IDLE_ST
                                                 : wwdt_pkg::SLEEP_ST;
                    end
                end
                wwdt_pkg::SLEEP_ST,
                wwdt_pkg::IDLE_ST: begin
                    if (wake_ev) begin
                        pwr_q <= wwdt_pkg::RUN_ST;
                    end
                end
                default: pwr_q <= wwdt_pkg::RUN_ST;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Counting chain
    // ------------------------------------------------------------------
    // Clear in power-save is ignored: the instruction cannot execute there
    assign cnt_clr = !enabled || CLK_SWITCH_DONE || enter_ev || wake_ev ||
                     (WATCHDOG_CLEAR_INSTR && pwr_q == wwdt_pkg::RUN_ST &&
                      clr_ok);

    wwdt_low_power_rc_osc #(
        .CLK_HZ(CLK_HZ),
        .LOW_POWER_RC_OSC_HZ(LOW_POWER_RC_OSC_HZ)
    ) u_low_power_rc_osc (
        .clk(CORE_CLK),
        .rst(SYS_RST),
        .ce(CLK_EN),
        .osc_on(enabled),
        .tick(tick)
    );

    wwdt_div u_div (
        .clk(CORE_CLK),
        .rst(SYS_RST),
        .ce(CLK_EN),
        .clr(cnt_clr),
        .tick(tick),
        .div7(cfg_q[`WWDT_CFG_PSA]),
        .pre_tick(pre_tick)
    );

    // Ratio 2^ps, so the terminal value is 2^ps - 1
    assign post_last = wwdt_pkg::wwdt_post_t'((16'h0001 << ps_cfg) -
                                              16'h0001);
    assign timeout_ev = enabled && pre_tick && post_q == post_last;
    // Last quarter of the period; ratios below 1:4 open the window fully
    assign clr_ok = !window_on || ps_cfg < 4'h2 ||
                    post_q >= post_last - (post_last >> 2);
    assign early_ev = WATCHDOG_CLEAR_INSTR && pwr_q == wwdt_pkg::RUN_ST &&
                      enabled && !clr_ok;

    always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            post_q <= 15'h0000;
        end else if (CLK_EN) begin
            if (cnt_clr || timeout_ev) begin
                post_q <= 15'h0000;
            end else if (pre_tick) begin
                post_q <= post_q + 15'h0001;
            end
        end
    end

    // ------------------------------------------------------------------
    // Outcome of a time-out
    // ------------------------------------------------------------------
    // Set wins over a software clear in the same cycle
    always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            timeout_flag_q <= 1'b0;
            early_flag_q <= 1'b0;
        end else if (CLK_EN) begin
            if (wr_stat && WB_SEL_I[0] && WB_DAT_I[`WWDT_STAT_TO]) begin
                timeout_flag_q <= 1'b0;
            end
            if (wr_stat && WB_SEL_I[0] && WB_DAT_I[`WWDT_STAT_EARLY]) begin
                early_flag_q <= 1'b0;
            end
            if (timeout_ev || early_ev) begin
                timeout_flag_q <= 1'b1;
            end
            if (early_ev) begin
                early_flag_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            WAKE_REQ <= 1'b0;
            WDT_RESET_REQ <= 1'b0;
            LOW_POWER_RC_OSC_EN <= 1'b0;
        end else if (CLK_EN) begin
            WAKE_REQ <= timeout_ev && pwr_q != wwdt_pkg::RUN_ST;
            WDT_RESET_REQ <= early_ev || (timeout_ev &&
                             pwr_q == wwdt_pkg::RUN_ST);
            LOW_POWER_RC_OSC_EN <= enabled;
        end
    end
endmodule : wwdt_top

//--- verif/wwdt_checker.sv
`timescale 1ns/1ps
module wwdt_checker (
    input wire logic CORE_CLK,
    input wire logic SYS_RST,
    input wire logic CLK_EN,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic WB_ACK_O,
    input wire logic WATCHDOG_CLEAR_INSTR,
    input wire logic POWER_SAVE_INSTR,
    input wire logic WAKE_OTHER,
    input wire logic WAKE_REQ,
    input wire logic WDT_RESET_REQ,
    input wire logic LOW_POWER_RC_OSC_EN
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (SYS_RST);
    logic asleep_q;
    // Lags the block by one edge, so the sleep and run checks below also check $past
    always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) asleep_q <= 1'h0;
        else if (POWER_SAVE_INSTR) asleep_q <= 1'h1;
        else if (WAKE_REQ || WAKE_OTHER) asleep_q <= 1'h0;
    end
    property p_ack;
        WB_CYC_I && WB_STB_I && !WB_ACK_O && CLK_EN |=> WB_ACK_O;
    endproperty
    a_ack: assert property (p_ack) else $error("bus ack late");
    property p_ack_pulse;
        WB_ACK_O && CLK_EN |=> !WB_ACK_O;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");
    property p_dat_idle;
        !WB_ACK_O |-> WB_DAT_O == 32'h0;
    endproperty
    a_dat_idle: assert property (p_dat_idle) else $error("data not zero");
    property p_rst_pulse;
        WDT_RESET_REQ |=> !WDT_RESET_REQ;
    endproperty
    a_rst_pulse: assert property (p_rst_pulse)
        else $error("reset request held");
    property p_wake_pulse;
        WAKE_REQ |=> !WAKE_REQ;
    endproperty
    a_wake_pulse: assert property (p_wake_pulse)
        else $error("wake held");
    property p_no_rst_sleep;
        asleep_q && $past(asleep_q) |-> !WDT_RESET_REQ;
    endproperty
    a_no_rst_sleep: assert property (p_no_rst_sleep)
        else $error("reset while asleep");
    property p_no_wake_run;
        !asleep_q && !$past(asleep_q) |-> !WAKE_REQ;
    endproperty
    a_no_wake_run: assert property (p_no_wake_run)
        else $error("wake while running");
    property p_clr_restart;
        WATCHDOG_CLEAR_INSTR && !asleep_q ##1 !WDT_RESET_REQ
            |=> (!WDT_RESET_REQ && !WAKE_REQ) [*8];
    endproperty
    a_clr_restart: assert property (p_clr_restart)
        else $error("time-out right after clear");
    property p_psave_restart;
        POWER_SAVE_INSTR |=> ##1 (!WAKE_REQ && !WDT_RESET_REQ) [*8];
    endproperty
    a_psave_restart: assert property (p_psave_restart)
        else $error("time-out right after power save");
    property p_osc_off;
        !LOW_POWER_RC_OSC_EN [*2] |-> !WAKE_REQ && !WDT_RESET_REQ;
    endproperty
    a_osc_off: assert property (p_osc_off)
        else $error("time-out with oscillator off");
endmodule : wwdt_checker

bind wwdt_top wwdt_checker u_wwdt_checker (.CORE_CLK(CORE_CLK),
    .SYS_RST(SYS_RST), .CLK_EN(CLK_EN), .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
    .WATCHDOG_CLEAR_INSTR(WATCHDOG_CLEAR_INSTR),
    .POWER_SAVE_INSTR(POWER_SAVE_INSTR), .WAKE_OTHER(WAKE_OTHER),
    .WAKE_REQ(WAKE_REQ), .WDT_RESET_REQ(WDT_RESET_REQ),
    .LOW_POWER_RC_OSC_EN(LOW_POWER_RC_OSC_EN));

//--- verif/wwdt_core_model.sv
`timescale 1ns/1ps
module wwdt_core_model (
    input wire logic clk,
    output logic clr,
    output logic psave,
    output logic idle,
    output logic wake,
    output logic csw
);
    initial {clr, psave, idle, wake, csw} = 5'h0;
    task automatic do_clear();
        @(posedge clk);
        clr <= 1'h1;
        @(posedge clk);
        clr <= 1'h0;
    endtask : do_clear
    // Qualifier flips after use so a stale level is never trusted
    task automatic do_psave(input logic i);
        @(posedge clk);
        {psave, idle} <= {1'h1, i};
        @(posedge clk);
        {psave, idle} <= {1'h0, ~i};
    endtask : do_psave
    task automatic do_wake();
        @(posedge clk);
        wake <= 1'h1;
        @(posedge clk);
        wake <= 1'h0;
    endtask : do_wake
    task automatic do_switch();
        @(posedge clk);
        csw <= 1'h1;
        @(posedge clk);
        csw <= 1'h0;
    endtask : do_switch
endmodule : wwdt_core_model

//--- verif/test_wwdt_top.sv
`timescale 1ns/1ps
`include "wwdt_defs.svh"
module test_wwdt_top;
    localparam int LOW_POWER_RC_OSC = 5000000;
    localparam int TICK = `WWDT_CLK_HZ / LOW_POWER_RC_OSC;
    logic CORE_CLK = 1'h0;
    logic SYS_RST = 1'h1;
    logic ce = 1'h1;
    logic cyc = 1'h0;
    logic stb = 1'h0;
    logic we = 1'h0;
    logic [3:0] adr = 4'h0;
    logic [31:0] dat = 32'h0;
    logic [31:0] rdat;
    logic [31:0] rnd;
    logic [31:0] cfg;
    logic w;
    logic r;
    wire [31:0] dat_o;
    wire ack, clr, ps, idle, wake, csw, wake_req, rst_req, osc;
    int n;
    int bad_count = 0;
    int checks = 0;
    int cyc_n = 0;
    logic [1:0] en_tab [4] = '{2'h3, 2'h2, 2'h0, 2'h1};

    always #50 CORE_CLK = ~CORE_CLK;

    wwdt_top #(.LOW_POWER_RC_OSC_HZ(LOW_POWER_RC_OSC)) u_wwdt_top (.CORE_CLK(CORE_CLK),
        .SYS_RST(SYS_RST), .CLK_EN(ce), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(dat),
        .WB_DAT_O(dat_o), .WB_ACK_O(ack), .WATCHDOG_CLEAR_INSTR(clr),
        .POWER_SAVE_INSTR(ps), .POWER_SAVE_IDLE(idle), .WAKE_OTHER(wake),
        .CLK_SWITCH_DONE(csw), .WAKE_REQ(wake_req),
        .WDT_RESET_REQ(rst_req), .LOW_POWER_RC_OSC_EN(osc));
    wwdt_core_model u_core (.clk(CORE_CLK), .clr(clr), .psave(ps),
        .idle(idle), .wake(wake), .csw(csw));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic int period(input int k, input int psa);
        return TICK * (psa != 0 ? 128 : 32) * (1 << k);
    endfunction : period
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic finish_test();
        if (bad_count == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : finish_test
    task automatic wb(input logic wr, input logic [3:0] a,
                      input logic [31:0] d);
        int k;
        k = 0;
        @(posedge CORE_CLK);
        {cyc, stb, we, adr, dat} <= {2'h3, wr, a, d};
        do begin
            @(posedge CORE_CLK);
            k++;
        end while (ack !== 1'h1);
        rdat = dat_o;
        {cyc, stb} <= 2'h0;
        check(k, 32'h2);
    endtask : wb
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] m,
                          input logic [31:0] e);
        wb(1'h0, a, 32'h0);
        check(rdat & m, e);
    endtask : rd_chk
    // Sampled before the edge lands, so a one-cycle pulse is not missed
    task automatic wait_out();
        n = 0;
        w = 1'h0;
        r = 1'h0;
        while (n < 3000 && w !== 1'h1 && r !== 1'h1) begin
            @(posedge CORE_CLK);
            n++;
            w = wake_req;
            r = rst_req;
        end
    endtask : wait_out
    task automatic expect_to(input int t, input logic wk);
        wait_out();
        check(n >= t - 1 && n <= t + 4, 1'h1);
        check({w, r}, {wk, ~wk});
    endtask : expect_to

    always @(posedge CORE_CLK) begin
        cyc_n++;
        if (cyc_n > 30000) begin
            bad_count++;
            finish_test();
        end
    end

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        rnd = 32'h5FCE;
        repeat (16) @(posedge CORE_CLK);
        SYS_RST <= 1'h0;
        rd_chk(`WWDT_ADR_CFG, 32'hFFFFFFFF, `WWDT_CFG_RST);
        rd_chk(`WWDT_ADR_CTRL, 32'h1, 32'h0);
        rd_chk(4'h2, 32'hFFFFFFFF, 32'h0);
        check(osc, 1'h1);
        for (int i = 0; i < 4; i++) begin
            rnd = lfsr(rnd);
            cfg = 32'h380 | (i[0] << 4) | (rnd & 32'h3);
            wb(1'h1, `WWDT_ADR_CFG, cfg);
            u_core.do_switch();
            repeat (30) @(posedge CORE_CLK);
            u_core.do_switch();
            expect_to(period(rnd[1:0], i[0]), 1'h0);
            rd_chk(`WWDT_ADR_STAT, 32'h1, 32'h1);
            wb(1'h1, `WWDT_ADR_STAT, 32'h1);
            rd_chk(`WWDT_ADR_STAT, 32'h1, 32'h0);
        end
        for (int i = 0; i < 2; i++) begin
            wb(1'h1, `WWDT_ADR_CFG, 32'h381);
            u_core.do_psave(i[0]);
            expect_to(period(1, 0), 1'h1);
            rd_chk(`WWDT_ADR_CTRL, 32'h6, i[0] ? 32'h4 : 32'h2);
            wb(1'h1, `WWDT_ADR_CTRL, 32'h0);
            rd_chk(`WWDT_ADR_CTRL, 32'h6, 32'h0);
        end
        // Outside wake must restart the count, so no early time-out
        u_core.do_psave(1'h0);
        repeat (90) @(posedge CORE_CLK);
        u_core.do_wake();
        expect_to(period(1, 0), 1'h0);
        wb(1'h1, `WWDT_ADR_CFG, 32'h303);
        u_core.do_switch();
        repeat (10) @(posedge CORE_CLK);
        u_core.do_clear();
        wait_out();
        check({n < 4, r}, 2'h3);
        rd_chk(`WWDT_ADR_STAT, 32'h2, 32'h2);
        u_core.do_switch();
        repeat (440) @(posedge CORE_CLK);
        rd_chk(`WWDT_ADR_CNT, 32'h7FFF, 32'h6);
        u_core.do_clear();
        expect_to(period(3, 0), 1'h0);
        wb(1'h1, `WWDT_ADR_CFG, 32'h383);
        u_core.do_switch();
        repeat (10) @(posedge CORE_CLK);
        u_core.do_clear();
        expect_to(period(3, 0), 1'h0);
        for (int i = 0; i < 4; i++) begin
            wb(1'h1, `WWDT_ADR_CFG, {22'h0, en_tab[i], 8'h80});
            repeat (2) @(posedge CORE_CLK);
            check(osc, en_tab[i] == 2'h3);
            cfg = en_tab[i] == 2'h3 ? 32'h4 : 32'h0;
            rd_chk(`WWDT_ADR_STAT, 32'h4, cfg);
        end
        wb(1'h1, `WWDT_ADR_CFG, 32'h280);
        wb(1'h1, `WWDT_ADR_CTRL, 32'h1);
        repeat (2) @(posedge CORE_CLK);
        check(osc, 1'h1);
        u_core.do_switch();
        // Frozen cycles must not count towards the period
        ce <= 1'h0;
        repeat (20) @(posedge CORE_CLK);
        ce <= 1'h1;
        expect_to(period(0, 0), 1'h0);
        wb(1'h1, `WWDT_ADR_CTRL, 32'h0);
        repeat (2) @(posedge CORE_CLK);
        check(osc, 1'h0);
        wb(1'h1, `WWDT_ADR_CTRL, 32'h1);
        SYS_RST <= 1'h1;
        repeat (2) @(posedge CORE_CLK);
        SYS_RST <= 1'h0;
        rd_chk(`WWDT_ADR_CTRL, 32'h1, 32'h0);
        finish_test();
    end
endmodule : test_wwdt_top
